// ==== design/spsmc_top.sv ====
/*
 * Serial program-mode controller: picks high- or low-voltage session entry,
 * holds config byte four low with its low-voltage enable, gives the shared
 * port pin back to general I/O, and runs the command/operand shift frame.
 * Assumes the programmer owns the serial clock and meets its own timing.
 */
// Notes on behaviour
// [RQ1] Low-voltage enable bit comes up set
// [RQ2] Enable clear makes shared pin plain I/O
// [RQ3] Enable bit writable only in high-voltage session
// [RQ4] Enable clear refuses low-voltage session entry
// [RQ5] High programming level always enters high-voltage session
// [RQ6] Shared pin is no I/O during low-voltage session
// [RQ7] Programmer sums code, masked config, protected IDs; the bench sums code words and masked config only, with no IDs
// [RQ8] Programmer reports low 16 bits of sum
// [RQ9] Programmer adds code memory word by word
// [RQ10] Programmer masks each config byte before adding
// [RQ11] Unimplemented config bits read back as ones
// [RQ12] Image places config and EEPROM at fixed bases
// [RQ13] Programmer holds clock high one millisecond
// [RQ14] Programmer holds clock low after programming
// [RQ15] Programmer waits five milliseconds for self-timed ops; the bench waits WR_WAIT, 8 mclk cycles (320 ns)
// [RQ16] Programmer spaces command and operand forty nanoseconds
// [RQ17] Programmer delays read clock after command
// [RQ18] Programmer clears sixteen-bit accumulator before summing
`timescale 1ns/10ps
`default_nettype none
`include "spsmc_defs.svh"

module spsmc_top
    import spsmc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Programming voltage pin comparator, high at the high programming level
    input wire logic programming_voltage_pin_hv,
    // Serial link
    input wire logic program_serial_clock,
    input wire logic program_serial_data_i,
    output logic program_serial_data_o,
    output logic program_serial_data_oe,
    // Shared port pin, also the low-voltage entry pin
    input wire logic shared_port_pin_i,
    output logic shared_port_pin_o,
    output logic shared_port_pin_oe,
    // General I/O side of the shared pin
    input wire logic port_out,
    input wire logic port_oe,
    output logic port_in,
    // Status
    output logic prog_mode_hv,
    output logic prog_mode_lv,
    output logic low_voltage_program_enable,
    output logic [`SPSMC_CFG_W-1:0] config_byte_four_low
);

    // ------------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------------
    spsmc_pins_if sp ();

    logic [`SPSMC_NPIN-1:0] raw_pins;

    always_comb begin
        raw_pins = '0;
        raw_pins[`SPSMC_PIN_CLK] = program_serial_clock;
        raw_pins[`SPSMC_PIN_DAT] = program_serial_data_i;
        raw_pins[`SPSMC_PIN_HV] = programming_voltage_pin_hv;
        raw_pins[`SPSMC_PIN_LVE] = shared_port_pin_i;
    end

    spsmc_sampler #(
        .N(`SPSMC_NPIN)
    ) u_sampler (
        .mclk(mclk),
        .rst_b(rst_b),
        .pins(raw_pins),
        .sp(sp)
    );

    logic hv_lvl;
    logic lve_lvl;
    logic dat_lvl;
    logic clk_rise;
    logic clk_fall;

    assign hv_lvl = sp.lvl[`SPSMC_PIN_HV];
    assign lve_lvl = sp.lvl[`SPSMC_PIN_LVE];
    assign dat_lvl = sp.lvl[`SPSMC_PIN_DAT];
    assign clk_rise = sp.rise[`SPSMC_PIN_CLK];
    assign clk_fall = sp.fall[`SPSMC_PIN_CLK];

    // ------------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------------
    spsmc_core_s st_r;
    spsmc_core_s st_nxt;

    logic lvp_bit;
    logic in_session;
    logic [`SPSMC_CMD_W-1:0] cmd_full;
    logic [`SPSMC_OPD_W-1:0] opd_full;
    logic [`SPSMC_CFG_W-1:0] cfg_read;

    assign lvp_bit = st_r.cfg[`SPSMC_LVP_BIT];
    assign in_session = (st_r.mode != SPSMC_RUN);
    assign cmd_full = {dat_lvl, st_r.cmd[`SPSMC_CMD_W-1:1]};
    assign opd_full = {dat_lvl, st_r.opd[`SPSMC_OPD_W-1:1]};
    assign cfg_read = st_r.cfg | ~`SPSMC_CFG_IMPL_MASK; // RQ11

    always_comb begin
        st_nxt = st_r;

        // Session selection
        unique case (st_r.mode)
            SPSMC_RUN: begin
                if (hv_lvl) begin
                    st_nxt.mode = SPSMC_HV; // RQ5
                end else if (lve_lvl && lvp_bit) begin
                    st_nxt.mode = SPSMC_LV; // RQ4
                end
            end
            SPSMC_HV: begin
                if (!hv_lvl) begin
                    st_nxt.mode = SPSMC_RUN;
                end
            end
            SPSMC_LV: begin
                if (hv_lvl) begin
                    st_nxt.mode = SPSMC_HV; // RQ5
                end else if (!lve_lvl) begin
                    st_nxt.mode = SPSMC_RUN;
                end
            end
            default: begin
                st_nxt.mode = SPSMC_RUN;
            end
        endcase

        if (st_nxt.mode != st_r.mode || !in_session) begin
            // Any session change starts a fresh frame
            st_nxt.cnt = `SPSMC_CNT_ZERO;
            st_nxt.cmd = '0;
            st_nxt.opd = '0;
            st_nxt.rd_sh = '0;
            st_nxt.dout = 1'b0;
            st_nxt.doe = 1'b0;
        end else begin
            // Read data leaves on the rising clock edge
            if (clk_rise && st_r.doe) begin
                st_nxt.dout = st_r.rd_sh[0];
            end
            // Input bits are taken on the falling clock edge
            if (clk_fall) begin
                st_nxt.rd_sh = {1'b0, st_r.rd_sh[`SPSMC_OPD_W-1:1]};
                if (st_r.cnt <= `SPSMC_CNT_CMD_LAST) begin
                    st_nxt.cmd = cmd_full;
                end else begin
                    st_nxt.opd = opd_full;
                end
                if (st_r.cnt == `SPSMC_CNT_CMD_LAST) begin
                    if (cmd_full == `SPSMC_CMD_RD_CFG) begin
                        st_nxt.rd_sh = {{(`SPSMC_OPD_W-`SPSMC_CFG_W){1'b0}}, cfg_read};
                        st_nxt.doe = 1'b1;
                    end
                end
                if (st_r.cnt == `SPSMC_CNT_FRAME_LAST) begin
                    st_nxt.cnt = `SPSMC_CNT_ZERO;
                    st_nxt.doe = 1'b0;
                    st_nxt.dout = 1'b0;
                    if (st_r.cmd == `SPSMC_CMD_WR_CFG && st_r.mode == SPSMC_HV) begin
                        st_nxt.cfg = opd_full[`SPSMC_CFG_W-1:0]; // RQ3
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt + `SPSMC_CNT_ONE;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r.mode <= SPSMC_RUN;
            st_r.cnt <= `SPSMC_CNT_ZERO;
            st_r.cmd <= '0;
            st_r.opd <= '0;
            st_r.rd_sh <= '0;
            st_r.cfg <= `SPSMC_CFG_FACTORY; // RQ1
            st_r.dout <= 1'b0;
            st_r.doe <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------------------
    always_comb begin
        if (!lvp_bit) begin
            shared_port_pin_o = port_out; // RQ2
            shared_port_pin_oe = port_oe;
            port_in = lve_lvl;
        end else begin
            shared_port_pin_o = 1'b0; // RQ6
            shared_port_pin_oe = 1'b0;
            port_in = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign program_serial_data_o = st_r.dout;
    assign program_serial_data_oe = st_r.doe;
    assign prog_mode_hv = (st_r.mode == SPSMC_HV);
    assign prog_mode_lv = (st_r.mode == SPSMC_LV);
    assign low_voltage_program_enable = lvp_bit;
    assign config_byte_four_low = st_r.cfg;

endmodule

`default_nettype wire

// ==== inc/spsmc_defs.svh ====
/*
 * Constants of the serial program-mode controller: pin slots, frame layout,
 * command codes and the config byte that holds the low-voltage enable.
 * Assumes nothing; definitions only.
 */
`ifndef SPSMC_DEFS_SVH
`define SPSMC_DEFS_SVH

// ----------------------------------------------------------------------------
// Sampled pin slots
// ----------------------------------------------------------------------------
`define SPSMC_NPIN 4
`define SPSMC_PIN_CLK 0
`define SPSMC_PIN_DAT 1
`define SPSMC_PIN_HV 2
`define SPSMC_PIN_LVE 3

// ----------------------------------------------------------------------------
// Frame layout: 4-bit command then 16-bit operand, LSB first
// ----------------------------------------------------------------------------
`define SPSMC_CMD_W 4
`define SPSMC_OPD_W 16
`define SPSMC_CNT_W 5
`define SPSMC_CNT_CMD_LAST 5'h03
`define SPSMC_CNT_OPD_FIRST 5'h04
`define SPSMC_CNT_FRAME_LAST 5'h13
`define SPSMC_CNT_ZERO 5'h00
`define SPSMC_CNT_ONE 5'h01

// ----------------------------------------------------------------------------
// Commands
// ----------------------------------------------------------------------------
`define SPSMC_CMD_WR_CFG 4'h1
`define SPSMC_CMD_RD_CFG 4'h2

// ----------------------------------------------------------------------------
// Config byte four low
// ----------------------------------------------------------------------------
`define SPSMC_CFG_W 8
`define SPSMC_CFG_FACTORY 8'h85
`define SPSMC_CFG_IMPL_MASK 8'hC5
`define SPSMC_LVP_BIT 2

`endif

// ==== inc/spsmc_pkg.sv ====
/*
 * Types of the serial program-mode controller.
 * Assumes spsmc_defs.svh on the include path.
 */
`include "spsmc_defs.svh"

package spsmc_pkg;

    // ------------------------------------------------------------------------
    // Programming session states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPSMC_RUN = 2'b00,
        SPSMC_HV = 2'b01,
        SPSMC_LV = 2'b10
    } spsmc_mode_e;

    // ------------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------------
    typedef struct packed {
        spsmc_mode_e mode;
        logic [`SPSMC_CNT_W-1:0] cnt;
        logic [`SPSMC_CMD_W-1:0] cmd;
        logic [`SPSMC_OPD_W-1:0] opd;
        logic [`SPSMC_OPD_W-1:0] rd_sh;
        logic [`SPSMC_CFG_W-1:0] cfg;
        logic dout;
        logic doe;
    } spsmc_core_s;

    // ------------------------------------------------------------------------
    // Pin sampler state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`SPSMC_NPIN-1:0] s1;
        logic [`SPSMC_NPIN-1:0] s2;
        logic [`SPSMC_NPIN-1:0] prev;
    } spsmc_samp_s;

endpackage

// ==== inc/spsmc_pins_if.sv ====
/*
 * Carrier between the pin sampler and the controller core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "spsmc_defs.svh"

interface spsmc_pins_if;
    logic [`SPSMC_NPIN-1:0] lvl;
    logic [`SPSMC_NPIN-1:0] rise;
    logic [`SPSMC_NPIN-1:0] fall;

    modport sampler (output lvl, output rise, output fall);
    modport core (input lvl, input rise, input fall);
endinterface

`default_nettype wire

// ==== design/spsmc_sampler.sv ====
/*
 * Two-stage synchroniser and edge finder for the asynchronous link pins.
 * Assumes pins settle for at least two mclk periods between changes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "spsmc_defs.svh"

module spsmc_sampler
    import spsmc_pkg::*;
#(
    parameter int N = `SPSMC_NPIN
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Raw pins
    input wire logic [N-1:0] pins,
    // Sampled levels and edges
    spsmc_pins_if.sampler sp
);

    spsmc_samp_s st_r;
    spsmc_samp_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Edges look at the second stage and its delayed copy only
    assign sp.lvl = st_r.s2;
    assign sp.rise = st_r.s2 & ~st_r.prev;
    assign sp.fall = ~st_r.s2 & st_r.prev;

endmodule

`default_nettype wire

// ==== verification/spsmc_chk.sv ====
/* Port assertions of the program-mode controller.
   Assumes binding into spsmc_top, all on mclk. */
`timescale 1ns/10ps
`default_nettype none

module spsmc_chk
    import spsmc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Observed ports
    input wire logic programming_voltage_pin_hv,
    input wire logic shared_port_pin_o,
    input wire logic shared_port_pin_oe,
    input wire logic port_out,
    input wire logic port_oe,
    input wire logic port_in,
    input wire logic prog_mode_hv,
    input wire logic prog_mode_lv,
    input wire logic low_voltage_program_enable,
    input wire logic [7:0] config_byte_four_low
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    lve_reset_a: assert property ($rose(rst_b) |-> config_byte_four_low == 8'h85)
        else $error("config byte not at reset value");
    lve_bit_a: assert property (low_voltage_program_enable == config_byte_four_low[2])
        else $error("enable output differs from config bit");
    pin_release_a: assert property (
        !low_voltage_program_enable |->
        {shared_port_pin_o, shared_port_pin_oe} == {port_out, port_oe})
        else $error("shared pin not handed to general I/O");
    pin_claimed_a: assert property (
        low_voltage_program_enable |-> !shared_port_pin_oe && !port_in)
        else $error("shared pin acts as I/O while claimed");
    cfg_guard_a: assert property (!prog_mode_hv |=> $stable(config_byte_four_low))
        else $error("config byte changed outside high-voltage session");
    lv_refused_a: assert property (
        !low_voltage_program_enable && !prog_mode_lv |=> !prog_mode_lv)
        else $error("low-voltage session entered while disabled");
    hv_entry_a: assert property ($rose(programming_voltage_pin_hv) |-> ##[1:4] prog_mode_hv)
        else $error("high-voltage session not entered");
    hv_wins_a: assert property (
        $past(rst_b, 3) && $past(rst_b, 2) && $past(rst_b) &&
        $past(programming_voltage_pin_hv, 3) && $past(programming_voltage_pin_hv, 2)
        |-> prog_mode_hv && !prog_mode_lv)
        else $error("high-voltage session not held while pin is high");
endmodule

bind spsmc_top spsmc_chk u_chk (
    .mclk, .rst_b, .programming_voltage_pin_hv, .shared_port_pin_o, .shared_port_pin_oe,
    .port_out, .port_oe, .port_in, .prog_mode_hv, .prog_mode_lv,
    .low_voltage_program_enable, .config_byte_four_low
);

`default_nettype wire

// ==== verification/spsmc_prog_model.sv ====
/* Programmer model: serial clock and data frames, read-back of the device.
   Assumes data output and enable of spsmc_top on dev_o and dev_oe. */
`timescale 1ns/10ps
`default_nettype none

module spsmc_prog_model (
    // Clock
    input wire logic mclk,
    // Device side of the data line
    input wire logic dev_o,
    input wire logic dev_oe,
    // Link lines
    output logic sclk,
    output logic sdat
);
    logic pd = 1'b0;
    logic drv = 1'b0;
    logic idle = 1'b0;
    // Extra clock high and low hold around an externally timed write, in mclk cycles
    int prog_hi = 0;
    int prog_lo = 0;

    initial sclk = 1'b0;
    // Released line toggles so a stale level never reads as valid
    always @(posedge mclk) idle <= ~idle;
    assign sdat = dev_oe ? dev_o : (drv ? pd : idle);

    task automatic half();
        repeat (4) @(posedge mclk);
    endtask

    // Data changes on the rise, the device takes it on the fall
    task automatic frame(input logic [3:0] c, input logic [15:0] d, input logic rd,
                         output logic [15:0] q);
        logic [19:0] f;
        f = {d, c};
        q = 16'h0000;
        for (int i = 0; i < 20; i++) begin
            sclk <= 1'b1;
            drv <= !(rd && i > 3);
            pd <= f[i];
            half();
            if (i > 3) q[i-4] = sdat;
            if (i == 19) repeat (prog_hi) @(posedge mclk);
            sclk <= 1'b0;
            half();
            if (i == 3) half();
        end
        drv <= 1'b0;
        half();
        repeat (prog_lo) @(posedge mclk);
    endtask
endmodule

`default_nettype wire

// ==== verification/tb_serial_program_mode_and_checksum.sv ====
/* Bench for spsmc_top: sessions, config write and read-back, pin handover.
   Assumes spsmc_prog_model as programmer and spsmc_chk bound in. */
`timescale 1ns/10ps
`default_nettype none

module tb_serial_program_mode_and_checksum
    import spsmc_pkg::*;
;
    localparam int WR_WAIT = 8;
    localparam int PROG_HI = 25000;
    localparam int PROG_LO = 2500;
    localparam logic [23:0] CFG_BASE = 24'h300000;
    localparam logic [23:0] EE_BASE = 24'hF00000;
    logic mclk, rst_b, hv, ext, pin, port_out, port_oe;
    logic sclk, sdat, d_o, d_oe, sp_o, sp_oe, port_in, m_hv, m_lv, lve;
    logic [7:0] cfg, seed, w;
    logic [15:0] q, csum, csum_exp;
    int failures = 0;
    int tests_run = 0;

    assign pin = sp_oe ? sp_o : ext;

    spsmc_top dut (
        .mclk, .rst_b, .programming_voltage_pin_hv(hv),
        .program_serial_clock(sclk), .program_serial_data_i(sdat),
        .program_serial_data_o(d_o), .program_serial_data_oe(d_oe),
        .shared_port_pin_i(pin), .shared_port_pin_o(sp_o), .shared_port_pin_oe(sp_oe),
        .port_out, .port_oe, .port_in, .prog_mode_hv(m_hv), .prog_mode_lv(m_lv),
        .low_voltage_program_enable(lve), .config_byte_four_low(cfg)
    );

    spsmc_prog_model pm (
        .mclk, .dev_o(d_o), .dev_oe(d_oe), .sclk, .sdat
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Read-back of the config byte: unimplemented bits come back as ones
    function automatic logic [15:0] rd_exp(input logic [7:0] v);
        return {8'h00, v | 8'h3A};
    endfunction

    // Checksum step: code words whole, config bytes masked, EEPROM left out
    function automatic logic [15:0] cs_add(input logic [15:0] acc, input logic [23:0] a,
                                           input logic [15:0] v);
        if (a >= EE_BASE) begin
            return acc;
        end
        if (a >= CFG_BASE) begin
            return acc + 16'(v[7:0] & 8'hC5);
        end
        return acc + v;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (6) @(posedge mclk);
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        hv = 1'b0;
        ext = 1'b0;
        port_out = 1'b0;
        port_oe = 1'b0;
        seed = 8'h60;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk(16'({lve, cfg}), 16'h0185);
        ext <= 1'b1;
        settle();
        chk(16'({m_lv, sp_oe, port_in}), 16'h0004);
        pm.frame(4'h1, 16'h0000, 1'b0, q);
        pm.frame(4'h2, 16'h0000, 1'b1, q);
        chk(q, rd_exp(8'h85));
        hv <= 1'b1;
        settle();
        chk(16'({m_hv, m_lv}), 16'h0002);
        csum = 16'h0000;
        csum_exp = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            w = (k == 3) ? (seed & 8'hFB) : seed;
            pm.prog_hi = (k == 3) ? PROG_HI : 0;
            pm.prog_lo = (k == 3) ? PROG_LO : 0;
            pm.frame(4'h1, {~seed, w}, 1'b0, q);
            pm.prog_hi = 0;
            pm.prog_lo = 0;
            repeat (WR_WAIT) @(posedge mclk);
            pm.frame(4'h2, 16'h0000, 1'b1, q);
            chk(q, rd_exp(w));
            chk(16'(lve), 16'(w[2]));
            csum = cs_add(csum, 24'(k), {~seed, w});
            csum = cs_add(csum, CFG_BASE, q);
            csum = cs_add(csum, EE_BASE, {w, ~w});
            csum_exp = csum_exp + {~seed, w} + 16'(w & 8'hC5);
        end
        chk(csum, csum_exp);
        hv <= 1'b0;
        settle();
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            port_out <= seed[0];
            port_oe <= seed[1];
            ext <= seed[2];
            settle();
            w = {4'h0, seed[0], seed[1], seed[1] ? seed[0] : seed[2], 1'b0};
            chk(16'({4'h0, sp_o, sp_oe, port_in, m_lv}), 16'(w));
        end
        hv <= 1'b1;
        settle();
        chk(16'({m_hv, m_lv}), 16'h0002);
        hv <= 1'b0;
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk(16'({lve, cfg}), 16'h0185);
        summarize();
    end
endmodule

`default_nettype wire
